// File: sbt_defs.vh
// Constants for the sequential break trigger
`ifndef SBT_DEFS_VH
`define SBT_DEFS_VH

// Channel count and channel bit positions (bit n-1 carries channel n)
`define SBT_NCH 12
`define SBT_CH1 4'h0
`define SBT_CH2 4'h1
`define SBT_CH3 4'h2
`define SBT_CH4 4'h3
`define SBT_CH5 4'h4
`define SBT_CH6 4'h5
`define SBT_CH8 4'h7
`define SBT_CH9 4'h8
`define SBT_CH10 4'h9
`define SBT_CH11 4'ha

// Channel groups
`define SBT_CPU_CH_MASK 12'he3f
`define SBT_SB_CH_MASK 12'h180

// CPU sequencing modes
`define SBT_CPU_OFF 4'h0
`define SBT_CPU_P21 4'h1
`define SBT_CPU_P43 4'h2
`define SBT_CPU_P65 4'h3
`define SBT_CPU_P1110 4'h4
`define SBT_CPU_C3 4'h5
`define SBT_CPU_C8 4'ha
`define SBT_CPU_EXT 4'hb

// System-bus sequencing modes
`define SBT_SB_OFF 2'h0
`define SBT_SB_98 2'h1
`define SBT_SB_89 2'h2
`define SBT_SB_EXT 2'h3

// Prerequisite select codes: 1..12 name a channel
`define SBT_PRE_NONE 4'h0
`define SBT_PRE_LAST_CH 4'hc
`define SBT_PRE_FLAG 4'hd

// Flag action codes
`define SBT_ACT_KEEP 2'h0
`define SBT_ACT_SET 2'h1
`define SBT_ACT_CLR 2'h2

// Per-channel configuration field widths
`define SBT_SEL_W 4
`define SBT_ACT_W 2

// Chain geometry
`define SBT_PAIR_LEN 4'h2
`define SBT_LONGEST_CHAIN 4'h8
`define SBT_CHAIN_BASE_LEN 4'h3
`define SBT_FLAG_RESET 1'b0

`endif

// File: sbt_core.v
// Sequential break trigger: orders channel hits into program break requests
`timescale 1ns/100ps
`include "sbt_defs.vh"

// Notes on behaviour
// - Pair mode: channel 2 then 1 breaks
// - Pair mode: channel 4 then 3 breaks
// - Pair mode: channel 6 then 5 breaks
// - Pair mode: channel 11 then 10 breaks
// - Chain: 3, 2, 1 in order breaks
// - Chain: 4, 3, 2, 1 in order breaks
// - Chain: 5 down to 1 breaks
// - Chain: 6 down to 1 breaks
// - Chain: 10, then 6 down to 1
// - Chain: 11, 10, then 6 down to 1
// - Extended CPU mode allows any prerequisite combination
// - Channel prerequisite must have hit already
// - Flag prerequisite needs the sequence flag set
// - A prerequisite channel never breaks itself
// - Accepted CPU-channel hit sets, clears or keeps flag
// - Break returns the sequence flag to reset
// - System-bus channels get the same extended mode
module sbt_core (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Channel events from the comparators, bit n-1 is channel n
    input wire [11:0] i_hit,
    input wire [11:0] i_ch_valid,
    // Mode selection
    input wire [3:0] i_cpu_mode,
    input wire [1:0] i_sb_mode,
    // Extended mode configuration, four bits and two bits per channel
    input wire [47:0] i_prereq_sel,
    input wire [23:0] i_flag_action,
    // Break request and status
    output reg o_break,
    output reg [11:0] o_break_cause,
    output reg o_cpu_flag,
    output reg [2:0] o_cpu_stage,
    output reg o_sb_armed,
    output reg [11:0] o_ext_done
);

    // States of the fixed system-bus order
    localparam SB_IDLE = 1'b0;
    localparam SB_ARMED = 1'b1;

    // Length of the fixed CPU order selected by a mode, zero when none
    function [3:0] sbt_chain_len;
        input [3:0] mode;
        begin
            if (mode >= `SBT_CPU_P21 && mode <= `SBT_CPU_P1110) begin
                sbt_chain_len = `SBT_PAIR_LEN;
            end else if (mode >= `SBT_CPU_C3 && mode <= `SBT_CPU_C8) begin
                sbt_chain_len = mode - `SBT_CPU_C3 + `SBT_CHAIN_BASE_LEN;
            end else begin
                sbt_chain_len = 4'h0;
            end
        end
    endfunction

    // Channel that the fixed order expects at a given stage
    function [3:0] sbt_chain_ch;
        input [3:0] mode;
        input [2:0] stage;
        reg [3:0] pos;
        begin
            pos = 4'h0;
            sbt_chain_ch = `SBT_CH1;
            case (mode)
                `SBT_CPU_P21: begin
                    sbt_chain_ch = (stage == 3'h0) ? `SBT_CH2 : `SBT_CH1;
                end
                `SBT_CPU_P43: begin
                    sbt_chain_ch = (stage == 3'h0) ? `SBT_CH4 : `SBT_CH3;
                end
                `SBT_CPU_P65: begin
                    sbt_chain_ch = (stage == 3'h0) ? `SBT_CH6 : `SBT_CH5;
                end
                `SBT_CPU_P1110: begin
                    sbt_chain_ch = (stage == 3'h0) ? `SBT_CH11 : `SBT_CH10;
                end
                default: begin
                    // Every long chain is the tail of the eight-channel one
                    pos = `SBT_LONGEST_CHAIN - sbt_chain_len(mode) + {1'b0, stage};
                    case (pos)
                        4'h0: sbt_chain_ch = `SBT_CH11;
                        4'h1: sbt_chain_ch = `SBT_CH10;
                        4'h2: sbt_chain_ch = `SBT_CH6;
                        4'h3: sbt_chain_ch = `SBT_CH5;
                        4'h4: sbt_chain_ch = `SBT_CH4;
                        4'h5: sbt_chain_ch = `SBT_CH3;
                        4'h6: sbt_chain_ch = `SBT_CH2;
                        default: sbt_chain_ch = `SBT_CH1;
                    endcase
                end
            endcase
        end
    endfunction

    // Sequence state
    reg [2:0] cpu_stage;
    reg sb_state;
    reg seq_flag;
    reg [11:0] done;
    // Mode copies from the last edge, compared to catch a change
    reg [3:0] cpu_mode_q;
    reg [1:0] sb_mode_q;

    // Hits only count on channels whose condition software has set up
    wire [11:0] hit_v;
    assign hit_v = i_hit & i_ch_valid;

    // A new mode abandons the recorded stages, bus state and marks, but not the sequence flag
    wire mode_change;
    assign mode_change = (i_cpu_mode != cpu_mode_q) || (i_sb_mode != sb_mode_q);

    // Steps in the cycle of a mode change are dropped as well: a stage or a
    // mark left by the old mode must never complete an order of the new one
    wire seq_live;
    assign seq_live = !mode_change;

    // Fixed CPU orders, one stage per cycle: two chain channels hitting
    // together advance a single stage
    wire [3:0] cpu_len;
    wire [3:0] cpu_want;
    wire cpu_fixed;
    wire cpu_step;
    wire cpu_last;
    wire cpu_fixed_brk;
    reg [2:0] next_cpu_stage;

    assign cpu_len = sbt_chain_len(i_cpu_mode);
    assign cpu_want = sbt_chain_ch(i_cpu_mode, cpu_stage);
    assign cpu_fixed = (cpu_len != 4'h0);
    // Only the expected channel advances; others are ignored, not penalised
    assign cpu_step = cpu_fixed && hit_v[cpu_want];
    assign cpu_last = ({1'b0, cpu_stage} == (cpu_len - 4'h1));
    assign cpu_fixed_brk = cpu_step && cpu_last
        && seq_live;

    always @* begin
        next_cpu_stage = cpu_stage;
        if (!cpu_fixed || mode_change) begin
            next_cpu_stage = 3'h0;
        end else if (cpu_step) begin
            if (cpu_last) begin
                next_cpu_stage = 3'h0;
            end else begin
                next_cpu_stage = cpu_stage + 3'h1;
            end
        end
    end

    // Fixed system-bus orders; both share one state, the mode only swaps
    // which channel comes first
    wire sb_fixed;
    wire sb_first;
    wire sb_second;
    wire [3:0] sb_second_ch;
    reg next_sb_state;
    reg sb_brk;

    assign sb_fixed = (i_sb_mode == `SBT_SB_98) || (i_sb_mode == `SBT_SB_89);
    assign sb_first = (i_sb_mode == `SBT_SB_98) ? hit_v[`SBT_CH9] : hit_v[`SBT_CH8];
    assign sb_second_ch = (i_sb_mode == `SBT_SB_98) ? `SBT_CH8 : `SBT_CH9;
    assign sb_second = hit_v[sb_second_ch];

    always @* begin
        next_sb_state = sb_state;
        sb_brk = 1'b0;
        if (!sb_fixed || mode_change) begin
            next_sb_state = SB_IDLE;
        end else begin
            case (sb_state)
                SB_IDLE: begin
                    // The second channel alone does nothing before the first
                    if (sb_first) begin
                        next_sb_state = SB_ARMED;
                    end
                end
                SB_ARMED: begin
                    if (sb_second) begin
                        sb_brk = 1'b1;
                        next_sb_state = SB_IDLE;
                    end
                end
                default: begin
                    next_sb_state = SB_IDLE;
                end
            endcase
        end
    end

    // Extended any-combination mode, one slice per channel
    wire [11:0] ext_mask;
    wire [11:0] accepted;
    wire [11:0] want_set;
    wire [11:0] want_clr;
    wire [143:0] pre_map;
    reg [11:0] is_prereq;
    wire [11:0] ext_brk_vec;
    wire ext_brk;

    assign ext_mask = ((i_cpu_mode == `SBT_CPU_EXT) ? `SBT_CPU_CH_MASK : 12'h000)
        | ((i_sb_mode == `SBT_SB_EXT) ? `SBT_SB_CH_MASK : 12'h000);

    // Field widths of the per-channel select and action words
    localparam SEL_W = `SBT_SEL_W;
    localparam ACT_W = `SBT_ACT_W;

    // Only CPU channels move the CPU sequence flag
    wire [11:0] flag_mask;
    assign flag_mask = `SBT_CPU_CH_MASK;

    genvar g;
    generate
        for (g = 0; g < `SBT_NCH; g = g + 1) begin : gen_ch
            wire [3:0] sel;
            wire [1:0] act;
            wire sel_is_ch;
            wire pre_ok;

            // Spare select codes never accept, so a stray value opens no break
            assign sel = i_prereq_sel[SEL_W*g +: SEL_W];
            assign act = i_flag_action[ACT_W*g +: ACT_W];
            assign sel_is_ch = (sel != `SBT_PRE_NONE) && (sel <= `SBT_PRE_LAST_CH);
            // Registered progress only: a same-cycle prerequisite hit is too late
            assign pre_ok = (sel == `SBT_PRE_NONE) ? 1'b1 :
                (sel == `SBT_PRE_FLAG) ? seq_flag :
                sel_is_ch ? done[sel - 4'h1] : 1'b0;
            assign accepted[g] = seq_live && ext_mask[g] && hit_v[g] && pre_ok;
            assign want_set[g] = accepted[g] && flag_mask[g] && (act == `SBT_ACT_SET);
            assign want_clr[g] = accepted[g] && flag_mask[g] && (act == `SBT_ACT_CLR);
            // Dependant map: bit k set when this channel waits on channel k+1
            assign pre_map[12*g+11:12*g] = (ext_mask[g] && sel_is_ch) ?
                (12'h001 << (sel - 4'h1)) : 12'h000;
        end
    endgenerate

    // Mark every channel that an active dependant names as its prerequisite
    integer d;
    always @* begin
        is_prereq = 12'h000;
        for (d = 0; d < `SBT_NCH; d = d + 1) begin
            is_prereq = is_prereq | pre_map[12*d +: 12];
        end
    end

    // A prerequisite only arms its dependant
    assign ext_brk_vec = accepted & ~is_prereq;
    assign ext_brk = |ext_brk_vec;

    // Break merge: paths that break in one cycle all show in the cause,
    // so software can tell a fixed order from an extended one
    wire next_break;
    reg [11:0] next_cause;

    assign next_break = cpu_fixed_brk || sb_brk || ext_brk;

    always @* begin
        next_cause = ext_brk_vec;
        if (cpu_fixed_brk) begin
            next_cause = next_cause | (12'h001 << cpu_want);
        end
        if (sb_brk) begin
            next_cause = next_cause | (12'h001 << sb_second_ch);
        end
    end

    // Sequence flag and extended progress
    reg next_flag;
    reg [11:0] next_done;

    always @* begin
        next_flag = seq_flag;
        // Break first, so a set in the breaking cycle cannot survive it
        if (next_break) begin
            next_flag = `SBT_FLAG_RESET;
        end else if (|want_set) begin
            // Set wins when two channels disagree in the same cycle
            next_flag = 1'b1;
        end else if (|want_clr) begin
            next_flag = 1'b0;
        end
    end

    // Only accepted hits mark progress; a refused hit leaves no trace
    always @* begin
        if (next_break || mode_change) begin
            next_done = 12'h000;
        end else begin
            next_done = done | accepted;
        end
    end

    // State registers
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cpu_stage <= 3'h0;
            sb_state <= SB_IDLE;
            seq_flag <= `SBT_FLAG_RESET;
            done <= 12'h000;
            cpu_mode_q <= `SBT_CPU_OFF;
            sb_mode_q <= `SBT_SB_OFF;
        end else begin
            cpu_stage <= next_break ? 3'h0 : next_cpu_stage;
            sb_state <= next_break ? SB_IDLE : next_sb_state;
            seq_flag <= next_flag;
            done <= next_done;
            cpu_mode_q <= i_cpu_mode;
            sb_mode_q <= i_sb_mode;
        end
    end

    // Registered outputs, one cycle behind the deciding hit; the status
    // outputs mirror the state so progress can be watched from outside
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_break <= 1'b0;
            o_break_cause <= 12'h000;
            o_cpu_flag <= `SBT_FLAG_RESET;
            o_cpu_stage <= 3'h0;
            o_sb_armed <= 1'b0;
            o_ext_done <= 12'h000;
        end else begin
            o_break <= next_break;
            o_break_cause <= next_break ? next_cause : o_break_cause;
            o_cpu_flag <= next_flag;
            o_cpu_stage <= next_break ? 3'h0 : next_cpu_stage;
            o_sb_armed <= next_break ? 1'b0 : next_sb_state;
            o_ext_done <= next_done;
        end
    end

endmodule

// File: sbt_core_props.sv
// Checker for the sequential break trigger ports
`timescale 1ns/100ps
module sbt_core_props (
    // Clock and reset
    input wire i_clk,
    input wire i_resetn,
    // Inputs
    input wire [11:0] i_hit,
    input wire [11:0] i_ch_valid,
    input wire [3:0] i_cpu_mode,
    input wire [1:0] i_sb_mode,
    input wire [47:0] i_prereq_sel,
    input wire [23:0] i_flag_action,
    // Outputs
    input wire o_break,
    input wire [11:0] o_break_cause,
    input wire o_cpu_flag,
    input wire [2:0] o_cpu_stage,
    input wire o_sb_armed,
    input wire [11:0] o_ext_done
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    AST_BRK_CLEAR: assert property (o_break |-> o_cpu_stage == 3'h0 && !o_sb_armed
        && o_ext_done == 12'h000) else $error("progress kept after break");
    AST_BRK_FLAG: assert property (o_break |-> !o_cpu_flag)
        else $error("flag kept after break");
    AST_P21: assert property (i_cpu_mode == 4'h1 && $stable(i_cpu_mode) && o_cpu_stage == 3'h1
        && $stable(i_sb_mode) && i_hit[0] && i_ch_valid[0] |=> o_break && o_break_cause[0])
        else $error("pair order did not break");
    AST_NO_EARLY: assert property (i_cpu_mode inside {[4'h1:4'ha]} && i_sb_mode == 2'h0
        && o_cpu_stage == 3'h0 |=> !o_break) else $error("fixed order broke early");
    AST_STAGE_STEP: assert property (o_cpu_stage != 3'h0
        |-> o_cpu_stage - $past(o_cpu_stage) <= 3'h1) else $error("stage skipped");
    AST_SB98: assert property (i_sb_mode == 2'h1 && $stable(i_sb_mode) && o_sb_armed
        && $stable(i_cpu_mode) && i_hit[7] && i_ch_valid[7] |=> o_break && o_break_cause[7])
        else $error("bus order did not break");
    AST_SB_NOARM: assert property (i_sb_mode inside {2'h1, 2'h2} && !o_sb_armed
        && i_cpu_mode == 4'h0 |=> !o_break) else $error("bus broke unarmed");
    AST_EXT_PRE: assert property (i_cpu_mode == 4'hb && i_hit == 12'h010
        && i_prereq_sel[19:16] == 4'h6 && !o_ext_done[5] |=> !o_break)
        else $error("unmet prerequisite broke");
endmodule

bind sbt_core sbt_core_props sbt_core_props_inst (.*);

// File: sbt_comp_model.sv
// Comparator model driving channel hit pulses and condition flags
`timescale 1ns/100ps
module sbt_comp_model (
    // Clock
    input wire i_clk,
    // Channel events
    output logic [11:0] o_hit,
    output logic [11:0] o_ch_valid
);
    initial begin
        o_hit = 12'h000;
        o_ch_valid = 12'h000;
    end
    // Conditions are programmed before any order relies on them
    task automatic set_valid(input logic [11:0] mask);
        o_ch_valid = mask;
    endtask
    // Gap of zero keeps the line high for a back-to-back hit
    task automatic step(input logic [3:0] ch, input int gap);
        o_hit = 12'h001 << (ch - 4'h1);
        @(posedge i_clk);
        #1;
        if (gap > 0)
            o_hit = 12'h000;
        repeat (gap) begin
            @(posedge i_clk);
            #1;
        end
    endtask
endmodule

// File: tb_top.sv
// Self-checking testbench for the sequential break trigger
`timescale 1ns/100ps
`include "sbt_defs.vh"
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] cpu_mode = 4'h0;
    logic [1:0] sb_mode = 2'h0;
    logic [47:0] pre_sel = 48'h0;
    logic [23:0] flag_act = 24'h0;
    logic [11:0] hit, valid, cause;
    logic brk, flag;
    logic [11:0] exp_q[$];
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] seqs[12] = '{32'h21, 32'h43, 32'h65, 32'hba, 32'h321, 32'h4321, 32'h54321,
        32'h654321, 32'ha654321, 32'hba654321, 32'h98, 32'h89};

    always #2.5 clk = ~clk;

    sbt_comp_model sbt_comp_model_inst (.i_clk(clk), .o_hit(hit), .o_ch_valid(valid));
    sbt_core sbt_core_inst (.i_clk(clk), .i_resetn(resetn), .i_hit(hit), .i_ch_valid(valid),
        .i_cpu_mode(cpu_mode), .i_sb_mode(sb_mode), .i_prereq_sel(pre_sel),
        .i_flag_action(flag_act), .o_break(brk), .o_break_cause(cause), .o_cpu_flag(flag),
        .o_cpu_stage(), .o_sb_armed(), .o_ext_done());

    task automatic cmp_cause(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp_cause({11'h000, got}, {11'h000, exp});
    endtask
    task automatic summarize();
        if (exp_q.size() != 0)
            cmp_cause(12'h000, exp_q.pop_front());
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Breaks are matched against notes in the order they were made
    always @(posedge clk) begin
        #2;
        if (brk === 1'b1) begin
            if (exp_q.size() > 0)
                cmp_cause(cause, exp_q.pop_front());
            else
                cmp_cause(cause, 12'h000);
        end
    end

    // Invalid hit, then the last channel alone, then the whole order with random gaps
    task automatic run_order(input int t);
        logic [31:0] s;
        int n;
        s = seqs[t];
        n = 0;
        for (int k = 0; k < 8; k++)
            if (s[4*k +: 4] != 4'h0)
                n = k + 1;
        cpu_mode = (t < 10) ? 4'(t + 1) : 4'h0;
        sb_mode = (t == 10) ? 2'h1 : (t == 11) ? 2'h2 : 2'h0;
        pre_sel = 48'({$urandom(), $urandom()});
        flag_act = 24'($urandom());
        sbt_comp_model_inst.set_valid(12'h000);
        @(posedge clk);
        #1;
        sbt_comp_model_inst.step(s[4*(n-1) +: 4], 1);
        sbt_comp_model_inst.set_valid(12'hfff);
        sbt_comp_model_inst.step(s[3:0], 2);
        for (int k = n - 1; k > 0; k--)
            sbt_comp_model_inst.step(s[4*k +: 4], $urandom_range(0, 2));
        exp_q.push_back(12'h001 << (s[3:0] - 4'h1));
        sbt_comp_model_inst.step(s[3:0], 2);
        $display("order test %0d done", t);
    endtask

    initial begin
        #50000;
        n_errors++;
        $display("unexpected at %0t: timeout %h %h", $time, 1'b0, 1'b1);
        summarize();
    end

    initial begin
        void'($urandom(32'h2464d765));
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
        @(posedge clk);
        #1;
        cmp_flag(flag, 1'b0);
        for (int t = 0; t < 12; t++)
            run_order(t);
        cpu_mode = `SBT_CPU_EXT;
        sb_mode = `SBT_SB_EXT;
        pre_sel = 48'h30009006d000;
        flag_act = 24'h000420;
        @(posedge clk);
        #1;
        sbt_comp_model_inst.step(4'h4, 1);
        sbt_comp_model_inst.step(4'h5, 1);
        sbt_comp_model_inst.step(4'h6, 1);
        cmp_flag(flag, 1'b1);
        sbt_comp_model_inst.step(4'h3, 1);
        cmp_flag(flag, 1'b0);
        sbt_comp_model_inst.step(4'h4, 1);
        sbt_comp_model_inst.step(4'h6, 1);
        exp_q.push_back(12'h008);
        sbt_comp_model_inst.step(4'h4, 1);
        cmp_flag(flag, 1'b0);
        sbt_comp_model_inst.step(4'h5, 1);
        sbt_comp_model_inst.step(4'h8, 1);
        sbt_comp_model_inst.step(4'h9, 1);
        exp_q.push_back(12'h080);
        sbt_comp_model_inst.step(4'h8, 2);
        $display("extended test done");
        // Reset in mid-order must drop the recorded first hit
        cpu_mode = 4'h1;
        sb_mode = 2'h0;
        @(posedge clk);
        #1;
        sbt_comp_model_inst.step(4'h2, 1);
        resetn = 1'b0;
        @(posedge clk);
        #1;
        resetn = 1'b1;
        @(posedge clk);
        #1;
        sbt_comp_model_inst.step(4'h1, 3);
        cmp_flag(flag, 1'b0);
        $display("reset test done");
        // A stage left by one pair must not finish the pair selected next
        sbt_comp_model_inst.step(4'h2, 1);
        cpu_mode = 4'h2;
        sbt_comp_model_inst.step(4'h3, 2);
        $display("mode change test done");
        summarize();
    end
endmodule
